/* File: rtl/sbl_defs.vh */
// opcode, prefix, idle address and reset constants for the sixteen-bit load sequencer
`ifndef SBL_DEFS_VH
`define SBL_DEFS_VH

`define SBL_PFX_PAGE2      8'h18
`define SBL_PFX_PAGE3      8'h1a
`define SBL_PFX_PAGE4      8'hcd

`define SBL_OP_LDDA_IMM    8'hcc
`define SBL_OP_LDDA_DIR    8'hdc
`define SBL_OP_LDDA_EXT    8'hfc
`define SBL_OP_LDDA_IND    8'hec
`define SBL_OP_LDSP_IMM    8'h8e
`define SBL_OP_LDSP_DIR    8'h9e
`define SBL_OP_LDSP_EXT    8'hbe
`define SBL_OP_LDSP_IND    8'hae
`define SBL_OP_LDIX_IMM    8'hce
`define SBL_OP_LDIX_DIR    8'hde
`define SBL_OP_LDIX_EXT    8'hfe
`define SBL_OP_LDIX_IND    8'hee

`define SBL_IDLE_ADDR      16'hffff
`define SBL_DIR_PAGE       8'h00
`define SBL_RST_PC         16'h0000
`define SBL_RST_CCR        8'hd0

`define SBL_CCR_V          1
`define SBL_CCR_Z          2
`define SBL_CCR_N          3

`endif

/* File: rtl/sbl_load16.v */
// sixteen-bit load decode and bus read sequencer
`timescale 1ns/100ps
`include "sbl_defs.vh"

// What this block does
// - negative flag takes bit 15 of the loaded word
// - zero flag set only when the whole loaded word is zero
// - overflow flag cleared by every load; other condition bits untouched
// - stack pointer load: byte at effective address goes to the upper half
// - stack pointer load: byte at effective address plus one to the lower half
// - x index load: first byte upper half, following byte lower half
// - y index load: lower half from effective address plus one
// - y index load: upper half from the effective address itself
// - double accumulator opcodes cc dc fc ec; prefix 18 ec is y indexed
// - stack pointer opcodes 8e 9e be ae; prefix 18 ae is y indexed
// - x index opcodes ce de fe ee; prefix cd ee is y indexed
// - y index via prefix 18 with ce de fe ee; prefix 1a ee is x indexed
// - all cycles read; high byte first; direct uses page 00; indexed adds idle ffff read
// - double accumulator load: first byte to a, next byte to b
module sbl_load16 (
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire [7:0]  bus_data_in,
  output wire [15:0] bus_addr_out,
  output wire        bus_rw_out,
  output wire [15:0] pc_out,
  output wire [7:0]  acc_a_out,
  output wire [7:0]  acc_b_out,
  output wire [15:0] stack_pointer_out,
  output wire [15:0] index_x_out,
  output wire [15:0] index_y_out,
  output wire [7:0]  ccr_out,
  output wire        load_done_out,
  output wire        unsupported_out
);

  ////////////////////////////////////////////////////////////////////////
  localparam [3:0] ST_FETCH = 4'h0;
  localparam [3:0] ST_PRE2  = 4'h1;
  localparam [3:0] ST_IMMH  = 4'h2;
  localparam [3:0] ST_IMML  = 4'h3;
  localparam [3:0] ST_DIRA  = 4'h4;
  localparam [3:0] ST_EXTH  = 4'h5;
  localparam [3:0] ST_EXTL  = 4'h6;
  localparam [3:0] ST_OFFS  = 4'h7;
  localparam [3:0] ST_IDLE  = 4'h8;
  localparam [3:0] ST_OPH   = 4'h9;
  localparam [3:0] ST_OPL   = 4'ha;

  localparam [2:0] MD_IMM   = 3'h0;
  localparam [2:0] MD_DIR   = 3'h1;
  localparam [2:0] MD_EXT   = 3'h2;
  localparam [2:0] MD_INDX  = 3'h3;
  localparam [2:0] MD_INDY  = 3'h4;

  localparam [1:0] TG_D     = 2'h0;
  localparam [1:0] TG_S     = 2'h1;
  localparam [1:0] TG_X     = 2'h2;
  localparam [1:0] TG_Y     = 2'h3;

  localparam [1:0] PG_1     = 2'h0;
  localparam [1:0] PG_2     = 2'h1;
  localparam [1:0] PG_3     = 2'h2;
  localparam [1:0] PG_4     = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // returns {valid, target, mode}
  function [5:0] sbl_decode;
    input [1:0] page;
    input [7:0] op;
    begin
      sbl_decode = 6'h00;
      case (page)
        PG_1: begin
          case (op)
            `SBL_OP_LDDA_IMM: sbl_decode = {1'b1, TG_D, MD_IMM};
            `SBL_OP_LDDA_DIR: sbl_decode = {1'b1, TG_D, MD_DIR};
            `SBL_OP_LDDA_EXT: sbl_decode = {1'b1, TG_D, MD_EXT};
            `SBL_OP_LDDA_IND: sbl_decode = {1'b1, TG_D, MD_INDX};
            `SBL_OP_LDSP_IMM: sbl_decode = {1'b1, TG_S, MD_IMM};
            `SBL_OP_LDSP_DIR: sbl_decode = {1'b1, TG_S, MD_DIR};
            `SBL_OP_LDSP_EXT: sbl_decode = {1'b1, TG_S, MD_EXT};
            `SBL_OP_LDSP_IND: sbl_decode = {1'b1, TG_S, MD_INDX};
            `SBL_OP_LDIX_IMM: sbl_decode = {1'b1, TG_X, MD_IMM};
            `SBL_OP_LDIX_DIR: sbl_decode = {1'b1, TG_X, MD_DIR};
            `SBL_OP_LDIX_EXT: sbl_decode = {1'b1, TG_X, MD_EXT};
            `SBL_OP_LDIX_IND: sbl_decode = {1'b1, TG_X, MD_INDX};
            default:          sbl_decode = 6'h00;
          endcase
        end
        PG_2: begin
          case (op)
            `SBL_OP_LDDA_IND: sbl_decode = {1'b1, TG_D, MD_INDY};
            `SBL_OP_LDSP_IND: sbl_decode = {1'b1, TG_S, MD_INDY};
            `SBL_OP_LDIX_IMM: sbl_decode = {1'b1, TG_Y, MD_IMM};
            `SBL_OP_LDIX_DIR: sbl_decode = {1'b1, TG_Y, MD_DIR};
            `SBL_OP_LDIX_EXT: sbl_decode = {1'b1, TG_Y, MD_EXT};
            `SBL_OP_LDIX_IND: sbl_decode = {1'b1, TG_Y, MD_INDY};
            default:          sbl_decode = 6'h00;
          endcase
        end
        PG_3: begin
          if (op == `SBL_OP_LDIX_IND) begin
            sbl_decode = {1'b1, TG_Y, MD_INDX};
          end
        end
        PG_4: begin
          if (op == `SBL_OP_LDIX_IND) begin
            sbl_decode = {1'b1, TG_X, MD_INDY};
          end
        end
        default: sbl_decode = 6'h00;
      endcase
    end
  endfunction

  // first state after the opcode byte, shared by both opcode states
  function [3:0] sbl_first;
    input [2:0] mode;
    begin
      case (mode)
        MD_IMM:  sbl_first = ST_IMMH;
        MD_DIR:  sbl_first = ST_DIRA;
        MD_EXT:  sbl_first = ST_EXTH;
        default: sbl_first = ST_OFFS;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg  [3:0]  state_ff;
  reg  [1:0]  page_ff;
  reg  [1:0]  target_ff;
  reg  [2:0]  mode_ff;
  reg  [15:0] addr_ff;
  reg  [15:0] pc_ff;
  reg  [15:0] ea_ff;
  reg  [7:0]  hi_ff;
  reg  [7:0]  acc_a_ff;
  reg  [7:0]  acc_b_ff;
  reg  [15:0] sp_ff;
  reg  [15:0] ix_ff;
  reg  [15:0] iy_ff;
  reg  [7:0]  ccr_ff;
  reg         done_ff;
  reg         unsup_ff;
  reg         rw_ff;

  // memory answers on this same clock, so the data pins need no synchroniser
  wire        is_prefix = (bus_data_in == `SBL_PFX_PAGE2) || (bus_data_in == `SBL_PFX_PAGE3) ||
                          (bus_data_in == `SBL_PFX_PAGE4);
  wire [1:0]  nxt_page  = (bus_data_in == `SBL_PFX_PAGE2) ? PG_2 :
                          (bus_data_in == `SBL_PFX_PAGE3) ? PG_3 : PG_4;
  wire [5:0]  dec       = sbl_decode((state_ff == ST_PRE2) ? page_ff : PG_1, bus_data_in);
  wire [15:0] pc_inc    = pc_ff + 16'h0001;
  wire [15:0] idx_base  = (mode_ff == MD_INDY) ? iy_ff : ix_ff;
  wire [15:0] word      = {hi_ff, bus_data_in};
  wire        finish    = (state_ff == ST_IMML) || (state_ff == ST_OPL);

  ////////////////////////////////////////////////////////////////////////
  // sequencer: state names the read cycle now ending at this edge
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff  <= ST_FETCH;
      page_ff   <= PG_1;
      target_ff <= TG_D;
      mode_ff   <= MD_IMM;
      addr_ff   <= `SBL_RST_PC;
      pc_ff     <= `SBL_RST_PC;
      ea_ff     <= 16'h0000;
      hi_ff     <= 8'h00;
      unsup_ff  <= 1'b0;
    end else begin
      unsup_ff <= 1'b0;
      case (state_ff)
        ST_FETCH, ST_PRE2: begin
          pc_ff   <= pc_inc;
          addr_ff <= pc_inc;
          if (state_ff == ST_FETCH && is_prefix) begin
            page_ff  <= nxt_page;
            state_ff <= ST_PRE2;
          end else if (dec[5]) begin
            target_ff <= dec[4:3];
            mode_ff   <= dec[2:0];
            state_ff  <= sbl_first(dec[2:0]);
          end else begin
            // foreign opcodes are skipped; this block only sequences the loads
            unsup_ff <= 1'b1;
            state_ff <= ST_FETCH;
          end
        end
        ST_IMMH: begin
          hi_ff    <= bus_data_in;
          pc_ff    <= pc_inc;
          addr_ff  <= pc_inc;
          state_ff <= ST_IMML;
        end
        ST_IMML: begin
          pc_ff    <= pc_inc;
          addr_ff  <= pc_inc;
          state_ff <= ST_FETCH;
        end
        ST_DIRA: begin
          ea_ff    <= {`SBL_DIR_PAGE, bus_data_in};
          addr_ff  <= {`SBL_DIR_PAGE, bus_data_in};
          pc_ff    <= pc_inc;
          state_ff <= ST_OPH;
        end
        ST_EXTH: begin
          hi_ff    <= bus_data_in;
          pc_ff    <= pc_inc;
          addr_ff  <= pc_inc;
          state_ff <= ST_EXTL;
        end
        ST_EXTL: begin
          ea_ff    <= word;
          addr_ff  <= word;
          pc_ff    <= pc_inc;
          state_ff <= ST_OPH;
        end
        ST_OFFS: begin
          ea_ff    <= idx_base + {8'h00, bus_data_in};
          addr_ff  <= `SBL_IDLE_ADDR;
          pc_ff    <= pc_inc;
          state_ff <= ST_IDLE;
        end
        ST_IDLE: begin
          addr_ff  <= ea_ff;
          state_ff <= ST_OPH;
        end
        ST_OPH: begin
          hi_ff    <= bus_data_in;
          addr_ff  <= ea_ff + 16'h0001;
          state_ff <= ST_OPL;
        end
        ST_OPL: begin
          addr_ff  <= pc_ff;
          state_ff <= ST_FETCH;
        end
        default: begin
          addr_ff  <= pc_ff;
          state_ff <= ST_FETCH;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register write-back at the end of the last operand read
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_a_ff <= 8'h00;
      acc_b_ff <= 8'h00;
      sp_ff    <= 16'h0000;
      ix_ff    <= 16'h0000;
      iy_ff    <= 16'h0000;
      ccr_ff   <= `SBL_RST_CCR;
      done_ff  <= 1'b0;
      rw_ff    <= 1'b1;
    end else begin
      // no store path in this block, so every cycle stays a read
      rw_ff   <= 1'b1;
      done_ff <= finish;
      if (finish) begin
        case (target_ff)
          TG_D: begin
            acc_a_ff <= hi_ff;
            acc_b_ff <= bus_data_in;
          end
          TG_S: begin
            sp_ff[15:8] <= hi_ff;
            sp_ff[7:0]  <= bus_data_in;
          end
          TG_X: ix_ff <= word;
          TG_Y: begin
            iy_ff[15:8] <= hi_ff;
            iy_ff[7:0]  <= bus_data_in;
          end
          default: acc_a_ff <= acc_a_ff;
        endcase
        ccr_ff[`SBL_CCR_N] <= word[15];
        ccr_ff[`SBL_CCR_Z] <= (word == 16'h0000);
        ccr_ff[`SBL_CCR_V] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus_addr_out      = addr_ff;
  assign bus_rw_out        = rw_ff;
  assign pc_out            = pc_ff;
  assign acc_a_out         = acc_a_ff;
  assign acc_b_out         = acc_b_ff;
  assign stack_pointer_out = sp_ff;
  assign index_x_out       = ix_ff;
  assign index_y_out       = iy_ff;
  assign ccr_out           = ccr_ff;
  assign load_done_out     = done_ff;
  assign unsupported_out   = unsup_ff;

endmodule

/* File: dv/sbl_load16_sva.sv */
// port-level checks for the sixteen-bit load sequencer
`timescale 1ns/100ps
module sbl_load16_sva (
  input wire        core_clk_in,
  input wire        rst_n_in,
  input wire [7:0]  bus_data_in,
  input wire [15:0] bus_addr_out,
  input wire        bus_rw_out,
  input wire [7:0]  acc_a_out,
  input wire [7:0]  acc_b_out,
  input wire [15:0] stack_pointer_out,
  input wire [15:0] index_x_out,
  input wire [15:0] index_y_out,
  input wire [7:0]  ccr_out,
  input wire        load_done_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // last two bytes read, high byte first; no reset needed, only read at done
  logic [7:0]  d1_ff;
  logic [7:0]  d2_ff;
  wire  [15:0] w_w = {d2_ff, d1_ff};
  always @(posedge core_clk_in) begin
    d1_ff <= bus_data_in;
    d2_ff <= d1_ff;
  end
  sequence s_done; load_done_out; endsequence
  sequence s_pair; $past(bus_addr_out, 1) == $past(bus_addr_out, 2) + 16'h0001; endsequence
  property p_read; bus_rw_out == 1'b1; endproperty
  property p_neg; s_done |-> ccr_out[3] == w_w[15]; endproperty
  property p_zero; s_done |-> ccr_out[2] == (w_w == 16'h0000); endproperty
  property p_ovf; s_done |-> !ccr_out[1]; endproperty
  property p_keep; $stable({ccr_out[7:4], ccr_out[0]}); endproperty
  property p_pair; s_done |-> s_pair; endproperty
  property p_sp; s_done ##0 $changed(stack_pointer_out) |-> stack_pointer_out == w_w; endproperty
  property p_x; s_done ##0 $changed(index_x_out) |-> index_x_out == w_w; endproperty
  property p_y; s_done ##0 $changed(index_y_out) |-> index_y_out == w_w; endproperty
  property p_d; s_done ##0 ($changed(acc_a_out) || $changed(acc_b_out)) |-> {acc_a_out, acc_b_out} == w_w; endproperty
  a_read: assert property (p_read) else $error("write cycle seen");
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  a_ovf: assert property (p_ovf) else $error("overflow flag set");
  a_keep: assert property (p_keep) else $error("other flags moved");
  a_pair: assert property (p_pair) else $error("operand reads not adjacent");
  a_sp: assert property (p_sp) else $error("stack pointer bytes wrong");
  a_x: assert property (p_x) else $error("x index bytes wrong");
  a_y: assert property (p_y) else $error("y index bytes wrong");
  a_d: assert property (p_d) else $error("accumulator bytes wrong");
endmodule
bind sbl_load16 sbl_load16_sva chk_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_data_in(bus_data_in),
  .bus_addr_out(bus_addr_out), .bus_rw_out(bus_rw_out), .acc_a_out(acc_a_out), .acc_b_out(acc_b_out),
  .stack_pointer_out(stack_pointer_out), .index_x_out(index_x_out), .index_y_out(index_y_out),
  .ccr_out(ccr_out), .load_done_out(load_done_out));

/* File: dv/sbl_mem_model.sv */
// zero-wait memory serving the sequencer's read cycles
`timescale 1ns/100ps
module sbl_mem_model (
  input  wire [15:0] addr_in,
  input  wire        rw_in,
  output wire [7:0]  data_out
);
  logic [7:0] mem [0:65535];
  // no write path: a write strobe shows inverted data rather than a kind echo
  assign data_out = rw_in ? mem[addr_in] : ~mem[addr_in];
endmodule

/* File: dv/test_sixteen_bit_load_execution.sv */
// self-checking bench for the sixteen-bit load sequencer
`timescale 1ns/100ps
module test_sixteen_bit_load_execution;
  typedef struct packed {logic [1:0] t; logic [15:0] w; logic [15:0] nx;} sbl_exp_t;
  logic        clk;
  logic        rst_n;
  wire  [7:0]  data;
  wire  [15:0] addr;
  wire         rw;
  wire  [7:0]  acc_a;
  wire  [7:0]  acc_b;
  wire  [7:0]  ccr;
  wire  [15:0] sp;
  wire  [15:0] ix;
  wire  [15:0] iy;
  wire         done;
  wire  [15:0] pc;
  wire         unsup;
  int          n_unsup;
  sbl_exp_t    q[$];
  sbl_exp_t    e;
  int          n_fail;
  int          comparisons;
  int          n;
  logic [15:0] pb;
  logic [15:0] xm;
  logic [15:0] ym;
  logic [15:0] got;
  logic [7:0]  base [4] = '{8'hcc, 8'h8e, 8'hce, 8'hce};
  logic [7:0]  moff [5] = '{8'h00, 8'h10, 8'h30, 8'h20, 8'h20};
  sbl_load16 dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .bus_data_in(data), .bus_addr_out(addr), .bus_rw_out(rw),
    .pc_out(pc), .acc_a_out(acc_a), .acc_b_out(acc_b), .stack_pointer_out(sp), .index_x_out(ix),
    .index_y_out(iy), .ccr_out(ccr), .load_done_out(done), .unsupported_out(unsup));
  sbl_mem_model mem_u (.addr_in(addr), .rw_in(rw), .data_out(data));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b);
    mem_u.mem[pb] = b;
    pb++;
  endtask
  // index values kept in their own 256-byte block so indexed data never collides
  task automatic emit(input int t, input int m);
    logic [15:0] w;
    logic [15:0] a;
    w = (t >= 2) ? (16'h8000 | (16'(n) << 8) | 16'($urandom & 32'h7f)) : ((n == 2) ? 16'h0000 : 16'($urandom));
    if (t == 3 || m == 4) begin
      put((t == 3) ? ((m == 3) ? 8'h1a : 8'h18) : ((t == 2) ? 8'hcd : 8'h18));
    end
    put(base[t] + moff[m]);
    a = (m == 1) ? {8'h00, 8'hc0 + 8'(2 * n)} : (m == 2) ? 16'h4000 + 16'(2 * n) : ((m == 3) ? xm : ym) + 16'(2 * n);
    if (m == 0) begin
      put(w[15:8]);
      put(w[7:0]);
    end else begin
      if (m == 2) begin
        put(a[15:8]);
      end
      put((m >= 3) ? 8'(2 * n) : a[7:0]);
      mem_u.mem[a] = w[15:8];
      mem_u.mem[a + 16'h0001] = w[7:0];
    end
    if (t == 2) xm = w;
    if (t == 3) ym = w;
    q.push_back('{2'(t), w, pb});
    n++;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #40000;
    n_fail++;
    close_out();
  end
  // sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge clk) begin
    if (rst_n && unsup === 1'b1) begin
      n_unsup++;
    end
    if (rst_n && done === 1'b1) begin
      if (q.size() == 0) begin
        chk("spare done", 16'h0001, 16'h0000);
      end else begin
        e = q.pop_front();
        got = (e.t == 2'd0) ? {acc_a, acc_b} : (e.t == 2'd1) ? sp : (e.t == 2'd2) ? ix : iy;
        chk("loaded word", got, e.w);
        chk("nzv", {13'h0000, ccr[3:1]}, {13'h0000, e.w[15], e.w == 16'h0000, 1'b0});
        chk("next fetch", addr, e.nx);
        chk("program counter", pc, e.nx);
        if (q.size() == 0) begin
          chk("skipped opcodes", 16'(n_unsup), 16'h0002);
        end
      end
    end
  end
  initial begin
    rst_n = 1'b0;
    n_fail = 0;
    comparisons = 0;
    n_unsup = 0;
    n = 0;
    pb = 16'h0000;
    xm = 16'h0000;
    ym = 16'h0000;
    void'($urandom(46));
    for (int i = 0; i < 65536; i++) begin
      mem_u.mem[i] = 8'h01;
    end
    emit(2, 0);
    emit(3, 0);
    for (int t = 0; t < 4; t++) begin
      for (int m = 0; m < 5; m++) begin
        emit(t, m);
      end
    end
    // a plain unknown opcode and a prefix with an unknown follower are skipped
    put(8'h01);
    put(8'h18);
    put(8'h01);
    emit(1, 2);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 400 && q.size() > 0; c++) begin
      @(posedge clk);
    end
    if (q.size() > 0) n_fail++;
    close_out();
  end
endmodule
